// *** core/clk_ctrl_device.sv ***
`timescale 1ns/1ps
`include "clk_ctrl_map.svh"
// Notes on behaviour
// - Main oscillator halts on STOP or stop bit
// - Subsystem oscillator never stops
// - Reset loads control register with 04H
// - Register takes single-bit and byte writes
// - Bit 7 set stops main oscillator
// - Bit 6 set disables sub feedback resistor
// - Bit 5 read-only active source status
// - Source bit and divider pick CPU clock
// - On sub clock, software stops main by bit
// - Feedback disable only when sub unused; the host still accepts a bit write selecting sub while it is disabled
// - Software writes zero to bit 3
// - No stop bit with external main clock
// - Shortest instruction takes two CPU clocks
module clk_ctrl_device (
  input  wire logic clk,        // 20 MHz system clock
  input  wire logic rst,        // Async reset, active high
  input  wire logic mainTick,   // Main oscillator edge, one cycle
  input  wire logic subTick,    // Subsystem oscillator edge, one cycle
  clk_ctrl_if.device bus        // CPU side
);
  logic                 mainOscStop_r;
  logic                 subFeedbackDisable_r;
  logic                 activeSourceStatus_r;
  logic                 cpuSourceSelect_r;
  logic [2:0]           cpuDivider_r;
  logic                 stopMode_r;
  clk_ctrl_pkg::byte_t  rdata_r;
  clk_ctrl_pkg::byte_t  regView;
  clk_ctrl_pkg::byte_t  wrValue;
  clk_ctrl_pkg::switch_state_e swState_r;
  logic                 mainGate_r;
  logic                 subGate_r;
  logic [3:0]           mainPre_r;
  logic                 mainDivTick;
  logic                 subDivTick;
  logic                 instrPhase_r;
  logic                 hit;
  logic [4:0]           subRatioM1;

  // ------------------------------------------------------------
  // Constants
  // ------------------------------------------------------------
  // Reset image of the control register; fields are picked from it
  localparam clk_ctrl_pkg::byte_t resetImage = `CLK_CTRL_RESET;

  assign hit        = bus.accAddr == `CLK_CTRL_ADDR;
  assign subRatioM1 = `CLK_SUB_DIV_M1;

  // ------------------------------------------------------------
  // Register access
  // ------------------------------------------------------------
  always_comb begin
    regView = 8'h0_0;
    regView[`CLK_CTRL_STOP_BIT]   = mainOscStop_r;
    regView[`CLK_CTRL_FBDIS_BIT]  = subFeedbackDisable_r;
    regView[`CLK_CTRL_STATUS_BIT] = activeSourceStatus_r;
    regView[`CLK_CTRL_SRC_BIT]    = cpuSourceSelect_r;
    regView[`CLK_CTRL_DIV_MSB:`CLK_CTRL_DIV_LSB] = cpuDivider_r;
  end

  // Single-bit write is read-modify-write of the whole byte
  always_comb begin
    wrValue = bus.accWdata;
    if (bus.accBitMode) begin
      wrValue = regView;
      wrValue[bus.accBitSel] = bus.accWdata[0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mainOscStop_r        <= resetImage[`CLK_CTRL_STOP_BIT];
      subFeedbackDisable_r <= resetImage[`CLK_CTRL_FBDIS_BIT];
      cpuSourceSelect_r    <= resetImage[`CLK_CTRL_SRC_BIT];
      cpuDivider_r         <= resetImage[`CLK_CTRL_DIV_MSB:`CLK_CTRL_DIV_LSB];
    end else if (bus.accWrite && hit) begin
      // Status and bit 3 are not stored, so writes cannot alter them
      mainOscStop_r        <= wrValue[`CLK_CTRL_STOP_BIT];
      subFeedbackDisable_r <= wrValue[`CLK_CTRL_FBDIS_BIT];
      cpuSourceSelect_r    <= wrValue[`CLK_CTRL_SRC_BIT];
      cpuDivider_r         <= wrValue[`CLK_CTRL_DIV_MSB:`CLK_CTRL_DIV_LSB];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 8'h0_0;
    end else if (bus.accRead && hit) begin
      rdata_r <= regView;
    end else begin
      rdata_r <= 8'h0_0;
    end
  end
  // Zero outside the answer cycle keeps a shared read bus quiet
  assign bus.accRdata = rdata_r;

  // ------------------------------------------------------------
  // Oscillator control
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stopMode_r <= 1'b0;
    end else if (bus.stopInstr) begin
      // A STOP beside a release wins, so standby is never skipped
      stopMode_r <= 1'b1;
    end else if (bus.stopRelease) begin
      stopMode_r <= 1'b0;
    end
  end

  assign bus.mainOscRun  = !(mainOscStop_r || stopMode_r);
  // Sub oscillator has no off switch; only its resistor is controlled
  assign bus.subOscRun   = 1'b1;
  assign bus.subFbEnable = !subFeedbackDisable_r;

  // ------------------------------------------------------------
  // Prescalers
  // ------------------------------------------------------------
  // Prescaler freezes while main is stopped, so a restart resumes in phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mainPre_r <= 4'h0;
    end else if (bus.mainOscRun && mainTick) begin
      mainPre_r <= mainPre_r + 4'h1;
    end
  end

  // Tick when all low divider bits roll over together: ratio 2^div for div up to 4, no tick above 4
  always_comb begin
    mainDivTick = bus.mainOscRun && mainTick;
    case (cpuDivider_r)
      3'h0:    mainDivTick = bus.mainOscRun && mainTick;
      3'h1:    mainDivTick = bus.mainOscRun && mainTick && mainPre_r[0];
      3'h2:    mainDivTick = bus.mainOscRun && mainTick && (&mainPre_r[1:0]);
      3'h3:    mainDivTick = bus.mainOscRun && mainTick && (&mainPre_r[2:0]);
      3'h4:    mainDivTick = bus.mainOscRun && mainTick && (&mainPre_r);
      default: mainDivTick = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // Subsystem divider
  // ------------------------------------------------------------
  // Counts source ticks only, so the sub period never depends on clk
  clk_tick_div i_clk_tick_div (
    .clk     (clk),
    .rst     (rst),
    .run     (subTick),
    .ratioM1 (subRatioM1),
    .tick    (subDivTick)
  );

  // ------------------------------------------------------------
  // Source switch
  // ------------------------------------------------------------
  // Old source gate closes on its own tick, or at once if main is the old source and stopped,
  // new opens on its own tick, so no truncated CPU period is ever produced.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      swState_r            <= clk_ctrl_pkg::SW_IDLE;
      mainGate_r           <= 1'b1;
      subGate_r            <= 1'b0;
      activeSourceStatus_r <= resetImage[`CLK_CTRL_STATUS_BIT];
    end else begin
      case (swState_r)
        clk_ctrl_pkg::SW_IDLE: begin
          if (cpuSourceSelect_r != activeSourceStatus_r) begin
            swState_r <= clk_ctrl_pkg::SW_WAIT_OLD_LOW;
          end
        end
        clk_ctrl_pkg::SW_WAIT_OLD_LOW: begin
          if (activeSourceStatus_r ? subDivTick : (mainDivTick || !bus.mainOscRun)) begin
            mainGate_r <= 1'b0;
            subGate_r  <= 1'b0;
            swState_r  <= clk_ctrl_pkg::SW_WAIT_NEW_LOW;
          end
        end
        clk_ctrl_pkg::SW_WAIT_NEW_LOW: begin
          if (cpuSourceSelect_r ? subDivTick : mainDivTick) begin
            mainGate_r           <= !cpuSourceSelect_r;
            subGate_r            <= cpuSourceSelect_r;
            activeSourceStatus_r <= cpuSourceSelect_r;
            swState_r            <= clk_ctrl_pkg::SW_IDLE;
          end
        end
        default: swState_r <= clk_ctrl_pkg::SW_IDLE;
      endcase
    end
  end

  // Gates change only on a tick or while main is stopped, so no short CPU period leaks out
  assign bus.cpuClkEn = (mainGate_r && mainDivTick) || (subGate_r && subDivTick);

  // ------------------------------------------------------------
  // Instruction timing
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      instrPhase_r <= 1'b0;
    end else if (bus.cpuClkEn) begin
      instrPhase_r <= !instrPhase_r;
    end
  end
  // Phase survives a source switch; only reset restarts the pairing
  assign bus.instrDone = bus.cpuClkEn && instrPhase_r;
endmodule

// *** core/clk_ctrl_host.sv ***
`timescale 1ns/1ps
`include "clk_ctrl_map.svh"
// Host end: CPU-side command port onto the clock control register.
module clk_ctrl_host (
  input  wire logic        clk,          // System clock
  input  wire logic        rst,          // Async reset
  input  wire logic [15:0] cmdAddr,      // Command address
  input  wire logic [7:0]  cmdWdata,     // Command write data
  input  wire logic        cmdWrite,     // Byte write strobe
  input  wire logic        cmdBitWrite,  // Single-bit write strobe
  input  wire logic [2:0]  cmdBitSel,    // Bit for single-bit write
  input  wire logic        cmdRead,      // Read strobe
  input  wire logic        cmdStop,      // STOP instruction request
  input  wire logic        cmdWake,      // Standby release
  input  wire logic        extMainClock, // Main clock driven externally
  output logic [7:0]       cmdRdata,     // Read data, one cycle later
  output logic             refused,      // Last write or STOP refused, held until the next one
  clk_ctrl_if.host         bus           // Device side
);
  logic [7:0] wdata;
  logic       onSub_r;
  logic       bad;
  logic       refused_r;

  // Shadow of the selected source bit; it follows the write, ahead of any pending switch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      onSub_r <= 1'b0;
    end else if (bus.accWrite && cmdAddr == `CLK_CTRL_ADDR) begin
      if (!cmdBitWrite) begin
        onSub_r <= wdata[`CLK_CTRL_SRC_BIT];
      end else if (cmdBitSel == 3'(`CLK_CTRL_SRC_BIT)) begin
        onSub_r <= cmdWdata[0];
      end
    end
  end

  always_comb begin
    wdata = cmdWdata;
    wdata[`CLK_CTRL_ZERO_BIT] = 1'b0;
    wdata[`CLK_CTRL_STATUS_BIT] = 1'b0;
  end

  // Refuse writes that would break oscillator usage limits
  always_comb begin
    bad = 1'b0;
    if (cmdWrite && cmdAddr == `CLK_CTRL_ADDR) begin
      if (extMainClock && wdata[`CLK_CTRL_STOP_BIT]) bad = 1'b1;
      if (wdata[`CLK_CTRL_FBDIS_BIT] && (wdata[`CLK_CTRL_SRC_BIT] || onSub_r)) begin
        bad = 1'b1;
      end
    end
    if (cmdBitWrite && cmdAddr == `CLK_CTRL_ADDR && cmdWdata[0]) begin
      if (extMainClock && cmdBitSel == 3'(`CLK_CTRL_STOP_BIT)) bad = 1'b1;
      if (onSub_r && cmdBitSel == 3'(`CLK_CTRL_FBDIS_BIT)) bad = 1'b1;
      if (cmdBitSel == 3'(`CLK_CTRL_ZERO_BIT)) bad = 1'b1;
    end
    if (cmdStop && extMainClock) bad = 1'b1;
    if (cmdStop && (onSub_r || !bus.mainOscRun)) bad = 1'b1;
  end

  assign bus.accWrite    = (cmdWrite || cmdBitWrite) && !bad;
  assign bus.accBitMode  = cmdBitWrite;
  assign bus.accBitSel   = cmdBitSel;
  assign bus.accAddr     = cmdAddr;
  assign bus.accWdata    = cmdBitWrite ? cmdWdata : wdata;
  assign bus.accRead     = cmdRead;
  assign bus.stopInstr   = cmdStop && !bad;
  assign bus.stopRelease = cmdWake;
  assign cmdRdata        = bus.accRdata;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      refused_r <= 1'b0;
    end else if (cmdWrite || cmdBitWrite || cmdStop) begin
      refused_r <= bad;
    end
  end
  assign refused = refused_r;
endmodule

// *** core/clk_ctrl_if.sv ***
`timescale 1ns/1ps
interface clk_ctrl_if;
  logic                 accWrite;     // CPU write strobe
  logic                 accRead;      // CPU read strobe
  logic                 accBitMode;   // Single-bit write when high
  clk_ctrl_pkg::bit_sel_t accBitSel;  // Bit index for single-bit write
  clk_ctrl_pkg::addr_t  accAddr;      // Address
  clk_ctrl_pkg::byte_t  accWdata;     // Write data (bit 0 for bit mode)
  clk_ctrl_pkg::byte_t  accRdata;     // Read data, cycle after read
  logic                 stopInstr;    // STOP instruction executed, pulse
  logic                 stopRelease;  // Standby release, pulse
  logic                 mainOscRun;   // Main oscillator enable
  logic                 subOscRun;    // Subsystem oscillator enable
  logic                 subFbEnable;  // Internal feedback resistor on
  logic                 cpuClkEn;     // One-cycle CPU clock tick
  logic                 instrDone;    // Shortest instruction complete

  modport device (
    input  accWrite, accRead, accBitMode, accBitSel, accAddr, accWdata, stopInstr,
    input  stopRelease,
    output accRdata, mainOscRun, subOscRun, subFbEnable, cpuClkEn, instrDone
  );
  modport host (
    output accWrite, accRead, accBitMode, accBitSel, accAddr, accWdata, stopInstr,
    output stopRelease,
    input  accRdata, mainOscRun, subOscRun, subFbEnable, cpuClkEn, instrDone
  );
endinterface

// *** core/clk_ctrl_map.svh ***
`ifndef CLK_CTRL_MAP_SVH
`define CLK_CTRL_MAP_SVH
// Register map and timing constants
`define CLK_CTRL_ADDR        16'hfffb
`define CLK_CTRL_RESET       8'h04
`define CLK_CTRL_STOP_BIT    7
`define CLK_CTRL_FBDIS_BIT   6
`define CLK_CTRL_STATUS_BIT  5
`define CLK_CTRL_SRC_BIT     4
`define CLK_CTRL_ZERO_BIT    3
`define CLK_CTRL_DIV_MSB     2
`define CLK_CTRL_DIV_LSB     0
`define CLK_CTRL_DIV_MAX     3'h4
`define CLK_SUB_FREQ_HZ      32768
`define CLK_SUB_DIV_M1       5'h01
`define CLK_SYNC_STAGES      2
`define CLK_INSTR_CYCLES     2
`endif

// *** core/clk_ctrl_pkg.sv ***
package clk_ctrl_pkg;
  typedef enum logic [1:0] {
    SW_IDLE,
    SW_WAIT_OLD_LOW,
    SW_WAIT_NEW_LOW
  } switch_state_e;

  typedef logic [7:0]  byte_t;
  typedef logic [15:0] addr_t;
  typedef logic [2:0]  bit_sel_t;
endpackage

// *** core/clk_tick_div.sv ***
`timescale 1ns/1ps
`include "clk_ctrl_map.svh"
module clk_tick_div (
  input  wire logic       clk,       // System clock
  input  wire logic       rst,       // Async reset
  input  wire logic       run,       // Source tick, counts when high
  input  wire logic [4:0] ratioM1,   // Divide ratio minus one
  output logic            tick       // One cycle per ratioM1+1 source ticks
);
  logic [4:0] cnt_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 5'h0_0;
    end else if (run) begin
      if (cnt_r >= ratioM1) begin
        cnt_r <= 5'h0_0;
      end else begin
        cnt_r <= cnt_r + 5'h0_1;
      end
    end
  end

  assign tick = run && (cnt_r >= ratioM1);
endmodule

// *** dv/clk_ctrl_assertions.sv ***
`timescale 1ns/1ps
`include "clk_ctrl_map.svh"
module clk_ctrl_assertions (
  input wire logic        clk,  // Clock
  input wire logic        rst,  // Reset
  input wire logic        accWrite,  // Write
  input wire logic        accRead,  // Read
  input wire logic        accBitMode,  // Bit mode
  input wire logic [2:0]  accBitSel,  // Bit index
  input wire logic [15:0] accAddr,  // Address
  input wire logic [7:0]  accWdata,  // Write data
  input wire logic [7:0]  accRdata,  // Read data
  input wire logic        stopInstr,  // Stop
  input wire logic        stopRelease,  // Wake
  input wire logic        mainOscRun,  // Main on
  input wire logic        subOscRun,  // Sub on
  input wire logic        subFbEnable,  // Resistor on
  input wire logic        cpuClkEn,  // CPU tick
  input wire logic        instrDone  // Done
);
  // ----------------------------
  // Clock control checks
  // ----------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence rd_s; accRead && accAddr == `CLK_CTRL_ADDR; endsequence
  sequence wr_s; accWrite && !accBitMode && accAddr == `CLK_CTRL_ADDR; endsequence
  sub_runs_a: assert property (subOscRun) else $error("sub stopped");
  stop_instr_a: assert property (stopInstr |=> !mainOscRun) else $error("stop ignored");
  stop_hold_a: assert property (!mainOscRun && !stopRelease && !accWrite
    |=> !mainOscRun) else $error("main restarted");
  stop_bit_a: assert property (wr_s ##0 accWdata[7] |=> !mainOscRun)
    else $error("stop bit ignored");
  bit_stop_a: assert property (accWrite && accBitMode && accBitSel == 3'h7
    && accWdata[0] && accAddr == `CLK_CTRL_ADDR |=> !mainOscRun) else $error("bit write lost");
  fb_bit_a: assert property (wr_s |=> subFbEnable == !$past(accWdata[6]))
    else $error("resistor wrong");
  fb_read_a: assert property (rd_s |=> accRdata[6] == !subFbEnable)
    else $error("resistor readback wrong");
  instr_tick_a: assert property (instrDone |-> cpuClkEn) else $error("done off tick");
  other_addr_a: assert property (accWrite && accAddr != `CLK_CTRL_ADDR && !stopInstr
    && !stopRelease |=> $stable(mainOscRun) && $stable(subFbEnable)) else $error("stray write");
endmodule

// *** dv/cpu_clock_select_control_tb.sv ***
`timescale 1ns/1ps
`include "clk_ctrl_map.svh"
module cpu_clock_select_control_tb;
  localparam logic [15:0] A = `CLK_CTRL_ADDR;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [2:0]  tickCnt = 3'h0;
  wire logic   mainTick = tickCnt[0];
  wire logic   subTick = &tickCnt;
  logic        extMainClock = 1'b0;
  logic [4:0]  cmdStb = 5'h00;  // Write, bit write, read, stop, wake
  logic [15:0] cmdAddr = A;
  logic [7:0]  cmdWdata = 8'h00;
  logic [7:0]  cmdRdata;
  logic        refused;
  int          nErrors = 0;
  int          numChecks = 0;
  clk_ctrl_if cif ();
  always #25 clk = ~clk;
  always @(posedge clk) tickCnt <= tickCnt + 3'h1;
  clk_ctrl_host i_clk_ctrl_host (.clk(clk), .rst(rst), .cmdAddr(cmdAddr), .cmdWdata(cmdWdata),
    .cmdWrite(cmdStb[4]), .cmdBitWrite(cmdStb[3]), .cmdBitSel(cmdWdata[6:4]),
    .cmdRead(cmdStb[2]), .cmdStop(cmdStb[1]), .cmdWake(cmdStb[0]),
    .extMainClock(extMainClock), .cmdRdata(cmdRdata), .refused(refused), .bus(cif));
  clk_ctrl_device i_clk_ctrl_device (.clk(clk), .rst(rst), .mainTick(mainTick),
    .subTick(subTick), .bus(cif));
  clk_ctrl_assertions i_clk_ctrl_assertions (.clk(clk), .rst(rst), .accWrite(cif.accWrite),
    .accRead(cif.accRead), .accBitMode(cif.accBitMode), .accBitSel(cif.accBitSel),
    .accAddr(cif.accAddr), .accWdata(cif.accWdata), .accRdata(cif.accRdata),
    .stopInstr(cif.stopInstr), .stopRelease(cif.stopRelease), .mainOscRun(cif.mainOscRun),
    .subOscRun(cif.subOscRun), .subFbEnable(cif.subFbEnable), .cpuClkEn(cif.cpuClkEn),
    .instrDone(cif.instrDone));
  // ----------------------------
  // Access tasks
  // ----------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    numChecks++;
    if (seen !== exp) begin
      nErrors++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // Bit writes carry index in data[6:4] and value in data[0]
  task automatic op(input logic [4:0] s, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    cmdStb <= s;
    cmdAddr <= a;
    cmdWdata <= d;
    @(posedge clk);
    cmdStb <= 5'h00;
    #1;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    op(5'h04, a, 8'h00);
    chk(cmdRdata, exp);
  endtask
  // Warm-up covers a source switch; 64 cycles is a whole number of periods
  task automatic rate(input logic [7:0] exp);
    logic [7:0] n = 8'h00;
    logic [7:0] m = 8'h00;
    repeat (64) @(posedge clk);
    repeat (64) begin
      @(posedge clk);
      #1;
      n = n + 8'(cif.cpuClkEn === 1'b1);
      m = m + 8'(cif.instrDone === 1'b1);
    end
    chk(n, exp);
    chk(m, exp >> 1);
  endtask
  task automatic report_and_stop;
    if (nErrors == 0 && numChecks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(A, 8'h04);
    rate(8'h02);
    for (int c = 0; c < 4; c++) begin
      op(5'h10, A, 8'(c));
      rate(8'h20 >> c);
    end
    op(5'h10, A, 8'h05);
    rate(8'h00);
    op(5'h10, A, 8'h10);
    rate(8'h04);
    rd(A, 8'h30);
    op(5'h02, A, 8'h00);
    chk(8'(refused), 8'h01);
    op(5'h08, A, 8'h61);
    chk(8'(refused), 8'h01);
    op(5'h10, A, 8'h90);
    chk(8'(cif.mainOscRun), 8'h00);
    rd(A, 8'hb0);
    op(5'h10, A, 8'h10);
    op(5'h10, A, 8'h04);
    rate(8'h02);
    rd(A, 8'h04);
    op(5'h08, A, 8'h71);
    rd(A, 8'h84);
    op(5'h08, A, 8'h70);
    op(5'h08, A, 8'h61);
    op(5'h08, A, 8'h51);
    chk(8'(cif.subFbEnable), 8'h00);
    rd(A, 8'h44);
    op(5'h08, A, 8'h31);
    chk(8'(refused), 8'h01);
    op(5'h08, A, 8'h60);
    op(5'h10, A, 8'h50);
    chk(8'(refused), 8'h01);
    rd(A, 8'h04);
    @(posedge clk) extMainClock <= 1'b1;
    op(5'h10, A, 8'h84);
    chk(8'(refused), 8'h01);
    op(5'h02, A, 8'h00);
    chk(8'(cif.mainOscRun), 8'h01);
    @(posedge clk) extMainClock <= 1'b0;
    op(5'h02, A, 8'h00);
    chk(8'(cif.mainOscRun), 8'h00);
    chk(8'(cif.subOscRun), 8'h01);
    op(5'h01, A, 8'h00);
    chk(8'(cif.mainOscRun), 8'h01);
    op(5'h10, 16'hfffa, 8'h80);
    chk(8'(cif.mainOscRun), 8'h01);
    op(5'h10, A, 8'h04);
    chk(8'(refused), 8'h00);
    report_and_stop;
  end
endmodule
